// File: src/l2_diag_defs.vh
// Constants for the level-2 cache diagnostic readback bank.
`ifndef L2_DIAG_DEFS_VH
`define L2_DIAG_DEFS_VH

// Register byte addresses; each 64-bit register is two 32-bit words, low word first.
`define ADDR_READ_TAG_LO 32'h10040018
`define ADDR_READ_TAG_HI 32'h1004001C
`define ADDR_ECC_TAG_LO 32'h10040038
`define ADDR_ECC_TAG_HI 32'h1004003C
`define ADDR_SETTINGS_LO 32'h10040058
`define ADDR_SETTINGS_HI 32'h1004005C
`define ADDR_CAPTURE_STATUS 32'h10040060

// Hidden registers written by address bits 11:8 with dummy data.
`define ADDR_WAY_EN_BASE 32'h10041000
`define ADDR_CACHE_DIS_BASE 32'h10042000
`define ADDR_MISC_CFG_BASE 32'h10043000
`define ADDR_HIDDEN_MASK 32'hFFFFF0FF
`define HIDDEN_ARG_HI 11
`define HIDDEN_ARG_LO 8

// Reset values of the hidden registers.
`define WAY_EN_RESET 2'h3
`define CACHE_DIS_RESET 4'h0
`define MISC_CFG_RESET 4'h0

// Cache size codes.
`define SIZE_128K 2'h0
`define SIZE_256K 2'h1
`define SIZE_512K 2'h2

// Tag capture register field positions.
`define TAG_IDX_LSB 5
`define TAG_IDX_MSB 14
`define TAG_B15 15
`define TAG_B16 16
`define TAG_BITS_LSB 17
`define TAG_BITS_MSB 38
`define TAG_ECC_LSB 40
`define TAG_ECC_MSB 45
`define TAG_WAY_LSB 46
`define TAG_WAY_MSB 47
`define TAG_DIRTY 48
`define TAG_VALID 49
`define TAG_DECC_LSB 50
`define TAG_DECC_MSB 59

// Settings readback field positions.
`define SET_CDIS_LSB 4
`define SET_CDIS_MSB 7
`define SET_LOWPRIO 8
`define SET_ECCDIS 9
`define SET_WAY_LSB 12
`define SET_WAY_MSB 13

// Capture status bit positions.
`define STAT_READ_LOADED 0
`define STAT_ECC_LOADED 1
`define STAT_ECC_COUNT_LSB 8
`define STAT_ECC_COUNT_MSB 15

// Timing.
`define SYS_CLK_PERIOD_NS 10
`define TAG_READ_HOLD_NS 20

`endif

// File: src/tag_capture_reg.v
// One 64-bit tag capture register with cache-size dependent packing.
`timescale 1ns/1ns
`default_nettype none
`include "l2_diag_defs.vh"

module tag_capture_reg
(
  input wire sys_clk,
  input wire load,
  input wire [1:0] cache_size,
  input wire [11:0] entry_index,
  input wire [23:0] entry_tag,
  input wire [5:0] entry_tag_ecc,
  input wire [1:0] entry_way,
  input wire entry_dirty,
  input wire entry_valid,
  input wire [9:0] entry_data_ecc,
  output reg [63:0] value_reg
);

  reg [63:0] value_next;

  // Index bits 16:5 arrive as entry_index; tag bits 40:17 arrive as entry_tag.
  always @*
  begin
    value_next = 64'h0000000000000000;
    value_next[`TAG_IDX_MSB:`TAG_IDX_LSB] = entry_index[9:0];
    if (cache_size == `SIZE_128K)
    begin
      value_next[`TAG_B15] = entry_tag[22];
    end
    else
    begin
      value_next[`TAG_B15] = entry_index[10];
    end
    if (cache_size == `SIZE_512K)
    begin
      value_next[`TAG_B16] = entry_index[11];
    end
    else
    begin
      value_next[`TAG_B16] = entry_tag[23];
    end
    value_next[`TAG_BITS_MSB:`TAG_BITS_LSB] = entry_tag[21:0];
    value_next[`TAG_ECC_MSB:`TAG_ECC_LSB] = entry_tag_ecc;
    value_next[`TAG_WAY_MSB:`TAG_WAY_LSB] = entry_way;
    value_next[`TAG_DIRTY] = entry_dirty;
    value_next[`TAG_VALID] = entry_valid;
    value_next[`TAG_DECC_MSB:`TAG_DECC_LSB] = entry_data_ecc;
  end

  // No reset: contents mean nothing until the first capture.
  always @(posedge sys_clk)
  begin
    if (load)
    begin
      value_reg <= value_next;
    end
  end

endmodule // tag_capture_reg
`default_nettype wire

// File: src/hidden_settings.v
// Hidden way-enable, cache-disable and misc configuration registers set by address bits.
`timescale 1ns/1ns
`default_nettype none
`include "l2_diag_defs.vh"

module hidden_settings
(
  input wire sys_clk,
  input wire rst,
  input wire wr_en,
  input wire [31:0] addr,
  output reg [1:0] way_enable_reg,
  output reg [3:0] cache_disable_reg,
  output reg [3:0] misc_cfg_reg
);

  wire [31:0] base;
  wire [3:0] arg;

  assign base = addr & `ADDR_HIDDEN_MASK;
  assign arg = addr[`HIDDEN_ARG_HI:`HIDDEN_ARG_LO];

  // The write data is dummy; only the address carries the setting.
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      way_enable_reg <= `WAY_EN_RESET;
      cache_disable_reg <= `CACHE_DIS_RESET;
      misc_cfg_reg <= `MISC_CFG_RESET;
    end
    else if (wr_en)
    begin
      if (base == `ADDR_WAY_EN_BASE)
      begin
        way_enable_reg <= arg[1:0];
      end
      else if (base == `ADDR_CACHE_DIS_BASE)
      begin
        cache_disable_reg <= arg;
      end
      else if (base == `ADDR_MISC_CFG_BASE)
      begin
        // Reserved bits 8 and 9 are dropped; software writes them as zero.
        misc_cfg_reg <= {arg[3:2], 2'h0};
      end
    end
  end

endmodule // hidden_settings
`default_nettype wire

// File: src/l2_cache_diag_readback_regs.v
// Diagnostic readback register bank of the level-2 cache.
`timescale 1ns/1ns
`default_nettype none
`include "l2_diag_defs.vh"

module l2_cache_diag_readback_regs
#(
  parameter THIRD_PERIPHERAL_REVISION = 1
)
(
  input wire sys_clk,
  input wire rst,
  input wire [31:0] bus_addr,
  input wire [31:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  output reg [31:0] bus_rdata,
  input wire [1:0] cache_size,
  input wire diag_read_strobe,
  input wire ecc_error_strobe,
  input wire [11:0] entry_index,
  input wire [23:0] entry_tag,
  input wire [5:0] entry_tag_ecc,
  input wire [1:0] entry_way,
  input wire entry_dirty,
  input wire entry_valid,
  input wire [9:0] entry_data_ecc,
  output reg regs_hold,
  output wire [1:0] way_enable,
  output wire [3:0] cache_disable,
  output wire low_prio_blocker,
  output wire ecc_cleanup_disable
);

  // Stall length after a tag register read, rounded up to whole cycles, at least one.
  localparam integer HOLD_RAW =
    (`TAG_READ_HOLD_NS + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS;
  localparam integer HOLD_CYCLES = (HOLD_RAW < 1) ? 1 : HOLD_RAW;
  localparam [3:0] HOLD_LOAD = HOLD_CYCLES[3:0];

  // One address decode serves the read mux, the stall and the status clear.
  // Hidden register writes decode their own bases inside the settings block.
  localparam [2:0] HIT_NONE = 3'h0;
  localparam [2:0] HIT_READ_TAG_LO = 3'h1;
  localparam [2:0] HIT_READ_TAG_HI = 3'h2;
  localparam [2:0] HIT_ECC_TAG_LO = 3'h3;
  localparam [2:0] HIT_ECC_TAG_HI = 3'h4;
  localparam [2:0] HIT_SETTINGS_LO = 3'h5;
  localparam [2:0] HIT_SETTINGS_HI = 3'h6;
  localparam [2:0] HIT_STATUS = 3'h7;

  wire [63:0] read_tag_value;
  wire [63:0] ecc_tag_value;
  wire [1:0] way_enable_q;
  wire [3:0] cache_disable_q;
  wire [3:0] misc_cfg_q;
  reg [63:0] settings_value;
  reg [31:0] status_value;
  reg [31:0] rdata_next;
  reg read_loaded_reg;
  reg read_loaded_next;
  reg ecc_loaded_reg;
  reg ecc_loaded_next;
  reg [7:0] ecc_count_reg;
  reg [7:0] ecc_count_next;
  reg [3:0] hold_count_reg;
  reg [3:0] hold_count_next;
  reg regs_hold_next;
  wire tag_reg_read;
  wire status_clear;
  reg [2:0] addr_hit;
  reg tag_hit;

  tag_capture_reg read_capture
  (
    .sys_clk(sys_clk),
    .load(diag_read_strobe),
    .cache_size(cache_size),
    .entry_index(entry_index),
    .entry_tag(entry_tag),
    .entry_tag_ecc(entry_tag_ecc),
    .entry_way(entry_way),
    .entry_dirty(entry_dirty),
    .entry_valid(entry_valid),
    .entry_data_ecc(entry_data_ecc),
    .value_reg(read_tag_value)
  );

  tag_capture_reg error_capture
  (
    .sys_clk(sys_clk),
    .load(ecc_error_strobe),
    .cache_size(cache_size),
    .entry_index(entry_index),
    .entry_tag(entry_tag),
    .entry_tag_ecc(entry_tag_ecc),
    .entry_way(entry_way),
    .entry_dirty(entry_dirty),
    .entry_valid(entry_valid),
    .entry_data_ecc(entry_data_ecc),
    .value_reg(ecc_tag_value)
  );

  hidden_settings settings
  (
    .sys_clk(sys_clk),
    .rst(rst),
    .wr_en(bus_wr),
    .addr(bus_addr),
    .way_enable_reg(way_enable_q),
    .cache_disable_reg(cache_disable_q),
    .misc_cfg_reg(misc_cfg_q)
  );

  assign way_enable = way_enable_q;
  assign cache_disable = cache_disable_q;
  assign low_prio_blocker = misc_cfg_q[2];
  assign ecc_cleanup_disable = misc_cfg_q[3];

  // Settings image; older revisions have no readback and see zero.
  always @*
  begin
    settings_value = 64'h0000000000000000;
    if (THIRD_PERIPHERAL_REVISION != 0)
    begin
      settings_value[`SET_CDIS_MSB:`SET_CDIS_LSB] = cache_disable_q;
      settings_value[`SET_LOWPRIO] = misc_cfg_q[2];
      settings_value[`SET_ECCDIS] = misc_cfg_q[3];
      settings_value[`SET_WAY_MSB:`SET_WAY_LSB] = way_enable_q;
    end
  end

  always @*
  begin
    status_value = 32'h00000000;
    status_value[`STAT_READ_LOADED] = read_loaded_reg;
    status_value[`STAT_ECC_LOADED] = ecc_loaded_reg;
    status_value[`STAT_ECC_COUNT_MSB:`STAT_ECC_COUNT_LSB] = ecc_count_reg;
  end

  always @*
  begin
    addr_hit = HIT_NONE;
    tag_hit = 1'b0;
    if (bus_addr == `ADDR_READ_TAG_LO)
    begin
      addr_hit = HIT_READ_TAG_LO;
      tag_hit = 1'b1;
    end
    else if (bus_addr == `ADDR_READ_TAG_HI)
    begin
      addr_hit = HIT_READ_TAG_HI;
      tag_hit = 1'b1;
    end
    else if (bus_addr == `ADDR_ECC_TAG_LO)
    begin
      addr_hit = HIT_ECC_TAG_LO;
      tag_hit = 1'b1;
    end
    else if (bus_addr == `ADDR_ECC_TAG_HI)
    begin
      addr_hit = HIT_ECC_TAG_HI;
      tag_hit = 1'b1;
    end
    else if (bus_addr == `ADDR_SETTINGS_LO)
    begin
      addr_hit = HIT_SETTINGS_LO;
    end
    else if (bus_addr == `ADDR_SETTINGS_HI)
    begin
      addr_hit = HIT_SETTINGS_HI;
    end
    else if (bus_addr == `ADDR_CAPTURE_STATUS)
    begin
      addr_hit = HIT_STATUS;
    end
  end

  assign tag_reg_read = bus_rd && tag_hit;

  assign status_clear = bus_wr && (addr_hit == HIT_STATUS);

  // Read decode; anything unmapped reads zero.
  always @*
  begin
    rdata_next = 32'h00000000;
    if (bus_rd)
    begin
      if (addr_hit == HIT_READ_TAG_LO)
      begin
        rdata_next = read_tag_value[31:0];
      end
      else if (addr_hit == HIT_READ_TAG_HI)
      begin
        rdata_next = read_tag_value[63:32];
      end
      else if (addr_hit == HIT_ECC_TAG_LO)
      begin
        rdata_next = ecc_tag_value[31:0];
      end
      else if (addr_hit == HIT_ECC_TAG_HI)
      begin
        rdata_next = ecc_tag_value[63:32];
      end
      else if (addr_hit == HIT_SETTINGS_LO)
      begin
        rdata_next = settings_value[31:0];
      end
      else if (addr_hit == HIT_SETTINGS_HI)
      begin
        rdata_next = settings_value[63:32];
      end
      else if (addr_hit == HIT_STATUS)
      begin
        rdata_next = status_value;
      end
    end
  end

  // Loaded flags tell software when a capture register holds meaning.
  // A capture in the cycle of a clear wins, so no event is hidden.
  always @*
  begin
    read_loaded_next = read_loaded_reg;
    ecc_loaded_next = ecc_loaded_reg;
    ecc_count_next = ecc_count_reg;
    if (status_clear)
    begin
      if (bus_wdata[`STAT_READ_LOADED])
      begin
        read_loaded_next = 1'b0;
      end
      if (bus_wdata[`STAT_ECC_LOADED])
      begin
        ecc_loaded_next = 1'b0;
        ecc_count_next = 8'h00;
      end
    end
    if (diag_read_strobe)
    begin
      read_loaded_next = 1'b1;
    end
    if (ecc_error_strobe)
    begin
      ecc_loaded_next = 1'b1;
      if (ecc_count_next != 8'hFF)
      begin
        ecc_count_next = ecc_count_next + 8'h01;
      end
    end
  end

  // The hold goes to the arbiters of the cache and control block registers.
  // The bank itself still answers in one cycle, so the hold only shields other registers.
  always @*
  begin
    hold_count_next = hold_count_reg;
    regs_hold_next = 1'b0;
    if (tag_reg_read)
    begin
      hold_count_next = HOLD_LOAD;
    end
    else if (hold_count_reg != 4'h0)
    begin
      hold_count_next = hold_count_reg - 4'h1;
    end
    if (hold_count_next != 4'h0)
    begin
      regs_hold_next = 1'b1;
    end
  end

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      bus_rdata <= 32'h00000000;
      read_loaded_reg <= 1'b0;
      ecc_loaded_reg <= 1'b0;
      ecc_count_reg <= 8'h00;
      hold_count_reg <= 4'h0;
      regs_hold <= 1'b0;
    end
    else
    begin
      bus_rdata <= rdata_next;
      read_loaded_reg <= read_loaded_next;
      ecc_loaded_reg <= ecc_loaded_next;
      ecc_count_reg <= ecc_count_next;
      hold_count_reg <= hold_count_next;
      regs_hold <= regs_hold_next;
    end
  end

endmodule // l2_cache_diag_readback_regs
`default_nettype wire

// File: bench/l2_cache_diag_readback_regs_checker.sv
// Concurrent checks on the ports of the diagnostic readback bank.
`timescale 1ns/1ns
`default_nettype none
`include "l2_diag_defs.vh"
module l2_cache_diag_readback_regs_checker
#(
  parameter THIRD_PERIPHERAL_REVISION = 1
)
(
  input wire sys_clk,
  input wire rst,
  input wire [31:0] bus_addr,
  input wire bus_wr,
  input wire bus_rd,
  input wire [31:0] bus_rdata,
  input wire diag_read_strobe,
  input wire ecc_error_strobe,
  input wire regs_hold,
  input wire [1:0] way_enable,
  input wire [3:0] cache_disable,
  input wire low_prio_blocker,
  input wire ecc_cleanup_disable
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire tag_rd = bus_rd && (bus_addr == `ADDR_READ_TAG_LO || bus_addr == `ADDR_READ_TAG_HI
    || bus_addr == `ADDR_ECC_TAG_LO || bus_addr == `ADDR_ECC_TAG_HI);
  wire [31:0] hid = bus_addr & `ADDR_HIDDEN_MASK;
  rdata_idle_a: assert property (!$past(bus_rd) |-> bus_rdata == 32'h0)
    else $error("read data not zero outside a read");
  hold_start_a: assert property (tag_rd |=> regs_hold [*2])
    else $error("stall not held after tag read");
  hold_cause_a: assert property ($rose(regs_hold) |-> $past(tag_rd))
    else $error("stall without tag read");
  hold_end_a: assert property (tag_rd ##1 !tag_rd [*2] |=> !regs_hold)
    else $error("stall too long");
  // The readback shows the hidden values as they stood when the read was taken.
  settings_read_a: assert property (
    bus_rd && bus_addr == `ADDR_SETTINGS_LO && THIRD_PERIPHERAL_REVISION != 0
    |=> bus_rdata == {18'h0, $past(way_enable), 2'h0, $past(ecc_cleanup_disable),
    $past(low_prio_blocker), $past(cache_disable), 4'h0})
    else $error("settings readback wrong");
  tag_reserved_a: assert property (tag_rd && bus_addr[2] |=>
    bus_rdata[31:28] == 4'h0 && !bus_rdata[7])
    else $error("tag reserved bits set");
  misc_write_a: assert property (bus_wr && hid == `ADDR_MISC_CFG_BASE |=>
    low_prio_blocker == $past(bus_addr[10]) && ecc_cleanup_disable == $past(bus_addr[11]))
    else $error("misc setting not taken");
  way_write_a: assert property (bus_wr && hid == `ADDR_WAY_EN_BASE |=>
    way_enable == $past(bus_addr[9:8]))
    else $error("way enable not taken");
  cdis_write_a: assert property (bus_wr && hid == `ADDR_CACHE_DIS_BASE |=>
    cache_disable == $past(bus_addr[11:8]))
    else $error("cache disable not taken");
  cover property (tag_rd);
  cover property (bus_wr && hid == `ADDR_MISC_CFG_BASE);
  cover property (ecc_error_strobe ##[1:20] diag_read_strobe);
endmodule // l2_cache_diag_readback_regs_checker
`default_nettype wire

// File: bench/l2_cache_diag_readback_regs_tb.sv
// Self-checking bench for the diagnostic readback register bank.
`timescale 1ns/1ns
`default_nettype none
`include "l2_diag_defs.vh"
module l2_cache_diag_readback_regs_tb;
  reg sys_clk = 1'b0;
  reg rst = 1'b1;
  reg [31:0] bus_addr = 32'h0;
  reg [31:0] bus_wdata = 32'h0;
  reg bus_wr = 1'b0;
  reg bus_rd = 1'b0;
  reg [1:0] cache_size = 2'h0;
  reg diag_read_strobe = 1'b0;
  reg ecc_error_strobe = 1'b0;
  reg [11:0] entry_index = 12'h0;
  reg [23:0] entry_tag = 24'h0;
  wire [31:0] bus_rdata;
  wire regs_hold;
  wire low_prio_blocker;
  wire ecc_cleanup_disable;
  wire [1:0] way_enable;
  wire [3:0] cache_disable;
  integer mismatches = 0;
  integer checks_done = 0;
  integer i;
  reg [3:0] cd;
  reg [63:0] exp_rd;
  reg [63:0] exp_ecc;
  always #5 sys_clk = ~sys_clk;
  // The side fields follow from the tag so that one value moves every field at once.
  l2_cache_diag_readback_regs dut (.sys_clk(sys_clk), .rst(rst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .cache_size(cache_size), .diag_read_strobe(diag_read_strobe),
    .ecc_error_strobe(ecc_error_strobe), .entry_index(entry_index), .entry_tag(entry_tag),
    .entry_tag_ecc(entry_tag[5:0]), .entry_way(entry_tag[7:6]), .entry_dirty(entry_tag[8]),
    .entry_valid(entry_tag[9]), .entry_data_ecc(entry_tag[19:10]), .regs_hold(regs_hold),
    .way_enable(way_enable), .cache_disable(cache_disable),
    .low_prio_blocker(low_prio_blocker), .ecc_cleanup_disable(ecc_cleanup_disable));
  task test_done;
    begin
      $display("Checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task cmp_data(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp)
      begin
        mismatches = mismatches + 1;
        $display("Error at %0t: data %h expected %h", $time, got, exp);
      end
    end
  endtask
  task cmp_out(input [3:0] got, input [3:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp)
      begin
        mismatches = mismatches + 1;
        $display("Error at %0t: output %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Hidden registers take their value from the address; the data is only a dummy.
  task wr(input [31:0] a);
    begin
      @(posedge sys_clk);
      bus_wr <= 1'b1;
      bus_addr <= a;
      bus_wdata <= 32'hFFFFFFFF;
      @(posedge sys_clk);
      bus_wr <= 1'b0;
    end
  endtask
  task rd(input [31:0] a, input [31:0] exp);
    begin
      @(posedge sys_clk);
      bus_rd <= 1'b1;
      bus_addr <= a;
      @(posedge sys_clk);
      bus_rd <= 1'b0;
      #1;
      cmp_data(bus_rdata, exp);
    end
  endtask
  task load(input sel, input [11:0] idx, input [23:0] tg);
    begin
      @(posedge sys_clk);
      entry_index <= idx;
      entry_tag <= tg;
      diag_read_strobe <= sel;
      ecc_error_strobe <= !sel;
      @(posedge sys_clk);
      diag_read_strobe <= 1'b0;
      ecc_error_strobe <= 1'b0;
    end
  endtask
  function [63:0] pack(input [1:0] sz);
    begin
      pack = 64'h0;
      pack[14:5] = entry_index[9:0];
      pack[15] = (sz == `SIZE_128K) ? entry_tag[22] : entry_index[10];
      pack[16] = (sz == `SIZE_512K) ? entry_index[11] : entry_tag[23];
      pack[38:17] = entry_tag[21:0];
      pack[59:40] = entry_tag[19:0];
    end
  endfunction
  initial
  begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    rd(`ADDR_SETTINGS_LO, 32'h00003000);
    rd(`ADDR_CAPTURE_STATUS, 32'h00000000);
    $display("Test reset done");
    for (i = 0; i < 4; i = i + 1)
    begin
      cd = i * 5;
      wr(`ADDR_WAY_EN_BASE | (i << 8));
      wr(`ADDR_CACHE_DIS_BASE | ({28'h0, cd} << 8));
      // Address bits 9:8 stay zero, as software must leave them for this register.
      wr(`ADDR_MISC_CFG_BASE | (i << 10));
      exp_rd[31:0] = {18'h0, i[1:0], 2'h0, i[1:0], cd, 4'h0};
      rd(`ADDR_SETTINGS_LO, exp_rd[31:0]);
      cmp_out({2'h0, low_prio_blocker, ecc_cleanup_disable}, {2'h0, i[0], i[1]});
      cmp_out({2'h0, way_enable}, {2'h0, i[1:0]});
      cmp_out(cache_disable, cd);
    end
    wr(`ADDR_SETTINGS_LO);
    rd(`ADDR_SETTINGS_LO, 32'h000033F0);
    rd(`ADDR_SETTINGS_HI, 32'h00000000);
    rd(32'h10040070, 32'h00000000);
    $display("Test settings done");
    // Size code 3 is not a documented size and packs like the 256KB case.
    for (i = 0; i < 4; i = i + 1)
    begin
      @(posedge sys_clk);
      cache_size <= i[1:0];
      load(1'b1, 12'hC33, 24'h3ABCDE);
      exp_rd = pack(i[1:0]);
      load(1'b0, 12'h3A5, 24'hC54321);
      exp_ecc = pack(i[1:0]);
      rd(`ADDR_READ_TAG_LO, exp_rd[31:0]);
      rd(`ADDR_READ_TAG_HI, exp_rd[63:32]);
      rd(`ADDR_ECC_TAG_LO, exp_ecc[31:0]);
      rd(`ADDR_ECC_TAG_HI, exp_ecc[63:32]);
    end
    cmp_out({3'h0, regs_hold}, 4'h1);
    repeat (2) @(posedge sys_clk);
    #1;
    cmp_out({3'h0, regs_hold}, 4'h0);
    rd(`ADDR_CAPTURE_STATUS, 32'h00000403);
    $display("Test capture done");
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rd(`ADDR_CAPTURE_STATUS, 32'h00000000);
    rd(`ADDR_SETTINGS_LO, 32'h00003000);
    cmp_out({low_prio_blocker, ecc_cleanup_disable, way_enable}, 4'h3);
    cmp_out(cache_disable, 4'h0);
    load(1'b0, 12'h155, 24'h0F0F0F);
    rd(`ADDR_CAPTURE_STATUS, 32'h00000102);
    wr(`ADDR_CAPTURE_STATUS);
    rd(`ADDR_CAPTURE_STATUS, 32'h00000000);
    $display("Test status done");
    test_done;
  end
  initial
  begin
    #100000;
    mismatches = mismatches + 1;
    test_done;
  end
endmodule // l2_cache_diag_readback_regs_tb
bind l2_cache_diag_readback_regs l2_cache_diag_readback_regs_checker
  #(.THIRD_PERIPHERAL_REVISION(THIRD_PERIPHERAL_REVISION)) chk (.sys_clk(sys_clk),
  .rst(rst), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
  .diag_read_strobe(diag_read_strobe), .ecc_error_strobe(ecc_error_strobe),
  .regs_hold(regs_hold), .way_enable(way_enable), .cache_disable(cache_disable),
  .low_prio_blocker(low_prio_blocker), .ecc_cleanup_disable(ecc_cleanup_disable));
`default_nettype wire
